/* File: hw/branch_call_clear_execute.sv */
`timescale 1ns/1ns
module branch_call_clear_execute (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [bcce_pkg::PC_W-1:0] pm_addr,
	input wire logic [15:0] pm_rdata,
	output bcce_pkg::dm_req_t dm_req,
	input wire logic [7:0] dm_rdata,
	input wire logic [11:0] index_base
);
	bcce_pkg::phase_t phase_q, phase_d;
	logic [15:0] ir_q;
	logic flush_q;
	logic call_pend_q;
	logic [7:0] k_lo_q;
	logic [bcce_pkg::PC_W-1:0] pc_q, pc_d;
	logic [bcce_pkg::PC_W-1:0] fetch_q;
	logic [7:0] status_q, status_d;
	logic [7:0] work_q;
	logic [3:0] bank_sel_q;
	logic [7:0] working_shadow_q;
	logic [7:0] status_shadow_q;
	logic [3:0] bank_select_shadow_q;
	logic [bcce_pkg::PC_W-1:0] return_stack_top_q;
	logic run_q;
	logic ext_en_q;
	logic [7:0] off_q;
	logic taken_q;
	logic [7:0] read_val_q;
	bcce_pkg::dm_req_t dm_d;
	bcce_pkg::dm_req_t dm_q;
	logic [31:0] prdata_d;

	// Decode, suppressed in the cycle after a jump
	wire live = !flush_q;
	wire is_br_ovf = live && !call_pend_q && ir_q[15:8] == bcce_pkg::OP_BR_OVF;
	wire is_br_zero = live && !call_pend_q && ir_q[15:8] == bcce_pkg::OP_BR_ZERO;
	wire is_branch = is_br_ovf || is_br_zero;
	wire is_call1 = live && !call_pend_q && ir_q[15:9] == bcce_pkg::OP_CALL;
	wire is_call2 = live && call_pend_q && ir_q[15:12] == bcce_pkg::OP_CALL2;
	wire is_clr = live && !call_pend_q && ir_q[15:9] == bcce_pkg::OP_CLR;
	wire br_cond = is_br_ovf ? status_q[bcce_pkg::OV_BIT] : status_q[bcce_pkg::Z_BIT];
	wire in_q1 = run_q && phase_q == bcce_pkg::Q1;
	wire in_q2 = run_q && phase_q == bcce_pkg::Q2;
	wire in_q3 = run_q && phase_q == bcce_pkg::Q3;
	wire in_q4 = run_q && phase_q == bcce_pkg::Q4;
	wire jump = in_q4 && taken_q;

	// Sign-extended 2n offset, bit 0 stays clear
	wire [bcce_pkg::PC_W-1:0] br_target = pc_q + {{12{off_q[7]}}, off_q, 1'b0};
	wire [bcce_pkg::PC_W-1:0] call_target = {ir_q[11:0], k_lo_q, 1'b0};

	// Data address: access bank split, indexed mode, or bank select
	wire [7:0] f_addr = ir_q[7:0];
	wire acc_bit = ir_q[8];
	wire idx_mode = ext_en_q && !acc_bit && f_addr <= bcce_pkg::IDX_LIMIT;
	wire [11:0] acc_addr = (f_addr >= bcce_pkg::ACC_SPLIT) ? {bcce_pkg::ACC_HI_BANK, f_addr} :
		{4'h0, f_addr};
	wire [11:0] idx_addr = index_base + {4'h0, f_addr};
	wire [11:0] gp_addr = {bank_sel_q, f_addr};
	wire [11:0] dm_addr_sel = acc_bit ? gp_addr : (idx_mode ? idx_addr : acc_addr);

	// Register bus decode
	wire apb_setup = psel && !penable;
	wire apb_wr = psel && penable && pwrite;
	wire hit_ctrl = paddr == bcce_pkg::OFF_CTRL;
	wire hit_status = paddr == bcce_pkg::OFF_STATUS;
	wire hit_pc = paddr == bcce_pkg::OFF_PC;
	wire hit_work = paddr == bcce_pkg::OFF_WORK;
	wire hit_bank = paddr == bcce_pkg::OFF_BANK;
	wire hit_shadow = paddr == bcce_pkg::OFF_SHADOW;
	wire hit_stack = paddr == bcce_pkg::OFF_STACK;
	wire hit_any = hit_ctrl || hit_status || hit_pc || hit_work || hit_bank || hit_shadow ||
		hit_stack;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;
	assign pm_addr = fetch_q;
	assign dm_req = dm_q;

	always_comb begin
		prdata_d = 32'h00000000;
		unique case (1'b1)
			hit_ctrl: prdata_d = {30'h00000000, ext_en_q, run_q};
			hit_status: prdata_d = {24'h000000, status_q};
			hit_pc: prdata_d = {11'h000, pc_q};
			hit_work: prdata_d = {24'h000000, work_q};
			hit_bank: prdata_d = {28'h0000000, bank_sel_q};
			hit_shadow: prdata_d = {12'h000, bank_select_shadow_q, status_shadow_q, working_shadow_q};
			hit_stack: prdata_d = {11'h000, return_stack_top_q};
			default: prdata_d = 32'h00000000;
		endcase
	end

	always_comb begin
		unique case (phase_q)
			bcce_pkg::Q1: phase_d = bcce_pkg::Q2;
			bcce_pkg::Q2: phase_d = bcce_pkg::Q3;
			bcce_pkg::Q3: phase_d = bcce_pkg::Q4;
			bcce_pkg::Q4: phase_d = bcce_pkg::Q1;
			default: phase_d = bcce_pkg::Q1;
		endcase
	end

	// Prefetch model: pc already points past the word now executing
	always_comb begin
		pc_d = pc_q;
		if (jump) begin
			pc_d = br_target;
		end else if (in_q4 && is_call2) begin
			pc_d = call_target + bcce_pkg::PC_STEP;
		end else if (in_q4) begin
			pc_d = pc_q + bcce_pkg::PC_STEP;
		end
	end

	// Hardware set of the zero flag wins over a software write
	always_comb begin
		status_d = status_q;
		if (apb_wr && hit_status) begin
			status_d = pwdata[7:0];
		end
		if (in_q4 && is_clr) begin
			status_d[bcce_pkg::Z_BIT] = 1'b1;
		end
	end

	// Requests are registered one quarter early so they stand in Q2 and Q4
	always_comb begin
		dm_d.addr = dm_addr_sel;
		dm_d.wdata = 8'h00;
		dm_d.re = in_q1 && is_clr;
		dm_d.we = in_q3 && is_clr;
	end

	// Registered so the far side sees each request for one whole quarter, glitch free
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dm_q <= bcce_pkg::dm_req_t'(22'h000000);
		end else begin
			dm_q <= dm_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= bcce_pkg::Q1;
		end else if (run_q) begin
			phase_q <= phase_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ir_q <= bcce_pkg::IR_RESET;
			flush_q <= 1'b1;
			call_pend_q <= 1'b0;
			pc_q <= bcce_pkg::PC_RESET;
		end else begin
			pc_q <= pc_d;
			if (in_q4) begin
				ir_q <= pm_rdata;
				flush_q <= taken_q;
				call_pend_q <= is_call1;
			end
		end
	end

	// Fetch address stands from Q4; a finishing call fetches its target at once
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fetch_q <= bcce_pkg::PC_RESET;
		end else if (in_q3) begin
			fetch_q <= is_call2 ? call_target : pc_q;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			off_q <= 8'h00;
			taken_q <= 1'b0;
			read_val_q <= 8'h00;
		end else begin
			if (in_q2 && is_branch) begin
				off_q <= ir_q[7:0];
			end
			if (in_q2 && is_clr) begin
				read_val_q <= dm_rdata;
			end
			if (in_q3) begin
				taken_q <= is_branch && br_cond;
			end else if (in_q4) begin
				taken_q <= 1'b0;
			end
		end
	end

	// Push happens in the first call cycle, before pc moves in the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			k_lo_q <= 8'h00;
			return_stack_top_q <= bcce_pkg::PC_RESET;
			working_shadow_q <= 8'h00;
			status_shadow_q <= bcce_pkg::STATUS_RESET;
			bank_select_shadow_q <= 4'h0;
		end else if (in_q4 && is_call1) begin
			k_lo_q <= ir_q[7:0];
			return_stack_top_q <= pc_q + bcce_pkg::RET_STEP;
			if (ir_q[8]) begin
				working_shadow_q <= work_q;
				status_shadow_q <= status_q;
				bank_select_shadow_q <= bank_sel_q;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_q <= bcce_pkg::STATUS_RESET;
			work_q <= 8'h00;
			bank_sel_q <= 4'h0;
			run_q <= 1'b0;
			ext_en_q <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			status_q <= status_d;
			if (apb_wr && hit_work) begin
				work_q <= pwdata[7:0];
			end
			if (apb_wr && hit_bank) begin
				bank_sel_q <= pwdata[3:0];
			end
			if (apb_wr && hit_ctrl) begin
				run_q <= pwdata[bcce_pkg::CTRL_RUN];
				ext_en_q <= pwdata[bcce_pkg::CTRL_EXT];
			end
			if (apb_setup) begin
				prdata <= prdata_d;
			end
		end
	end

	chk_phase_wrap: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4) |=> phase_q == bcce_pkg::Q1)
		else $error("quarter phase did not wrap to Q1");

	chk_branch_target: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && taken_q) |=> (pc_q == $past(br_target)) && flush_q)
		else $error("taken branch target or flush wrong");

	chk_branch_flags: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && is_branch && !apb_wr) |=> status_q == $past(status_q))
		else $error("branch changed status flags");

	chk_not_taken: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q3 && is_branch && !br_cond) ##1 in_q4 |=> !flush_q)
		else $error("untaken branch lost a cycle");

	chk_call_push: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && is_call1) |=> return_stack_top_q == $past(pc_q) + bcce_pkg::RET_STEP
		&& call_pend_q)
		else $error("call push address wrong");

	chk_call_shadow: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && is_call1 && !ir_q[8]) |=> $stable(working_shadow_q)
		&& $stable(status_shadow_q))
		else $error("shadow changed with shadow bit clear");

	chk_call_target: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && is_call2) |=> pc_q == $past(call_target) + bcce_pkg::PC_STEP
		&& !flush_q && pm_addr == $past(call_target))
		else $error("call did not finish in two cycles");

	chk_clr_write: assert property (@(posedge clk) disable iff (!arst_n)
		dm_req.we |-> dm_req.wdata == 8'h00 && phase_q == bcce_pkg::Q4)
		else $error("clear wrote nonzero or outside Q4");

	chk_clr_zflag: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && is_clr) |=> status_q[bcce_pkg::Z_BIT])
		else $error("clear did not set zero flag");

	chk_pc_even: assert property (@(posedge clk) disable iff (!arst_n)
		!pc_q[0] && !pm_addr[0])
		else $error("odd program address");

	chk_idx_addr: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q1 && is_clr && idx_mode) |=> dm_req.re
		&& dm_req.addr == $past(index_base) + {4'h0, $past(f_addr)})
		else $error("indexed clear address wrong");

	chk_offset_latch: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q2 && is_branch) |=> off_q == $past(f_addr))
		else $error("branch offset not taken in Q2");

	chk_ovf_untaken: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q3 && is_br_ovf && !status_q[bcce_pkg::OV_BIT]) |=> !taken_q)
		else $error("overflow branch taken with flag clear");

	chk_zero_taken: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q3 && is_br_zero && status_q[bcce_pkg::Z_BIT]) |=> taken_q)
		else $error("zero branch not taken with flag set");

	chk_flush_idle: assert property (@(posedge clk) disable iff (!arst_n)
		flush_q |-> !dm_req.re && !dm_req.we)
		else $error("data access during a flush cycle");

	chk_flush_step: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && flush_q) |=> pc_q == $past(pc_q) + bcce_pkg::PC_STEP)
		else $error("flush cycle moved pc wrongly");

	chk_fetch_q3: assert property (@(posedge clk) disable iff (!arst_n)
		$changed(pm_addr) |-> $past(in_q3))
		else $error("fetch address moved outside Q3");

	chk_clr_read: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q1 && is_clr) |=> dm_req.re && !dm_req.we && phase_q == bcce_pkg::Q2)
		else $error("clear read missing in Q2");

	chk_read_q2: assert property (@(posedge clk) disable iff (!arst_n)
		dm_req.re |-> phase_q == bcce_pkg::Q2)
		else $error("data read outside Q2");

	chk_read_keep: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q2 && is_clr) |=> read_val_q == $past(dm_rdata))
		else $error("clear read value not captured");

	chk_acc_high: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q1 && is_clr && !acc_bit && !idx_mode && f_addr[7])
		|=> dm_req.addr == {bcce_pkg::ACC_HI_BANK, $past(f_addr)})
		else $error("access bank upper half address wrong");

	chk_bank_addr: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q1 && is_clr && acc_bit) |=> dm_req.addr == {$past(bank_sel_q), $past(f_addr)})
		else $error("banked clear address wrong");

	chk_call_flags: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && (is_call1 || is_call2) && !apb_wr) |=> status_q == $past(status_q))
		else $error("call changed status flags");

	chk_shadow_copy: assert property (@(posedge clk) disable iff (!arst_n)
		(in_q4 && is_call1 && ir_q[8]) |=> working_shadow_q == $past(work_q)
		&& status_shadow_q == $past(status_q)
		&& bank_select_shadow_q == $past(bank_sel_q))
		else $error("shadow copy wrong with shadow bit set");
endmodule : branch_call_clear_execute

/* File: hw/bcce_pkg.sv */
// Contract
// - Decode e4 opcode as branch_on_overflow
// - Decode e0 opcode as branch_on_zero
// - Taken target is incremented pc plus 2n
// - Branch: one word, one or two cycles
// - Branch quarters: decode, literal, process, write pc
// - Two-word call loads 20-bit target into pc
// - Call pushes call address plus 4 first
// - Shadow bit copies working, status, bank select
// - Call takes two cycles, flags untouched
// - clear_data_register writes 00h and sets zero
// - Access bit picks access or general_purpose_bank
// - Extended mode indexes addresses up to 5fh
// - Clear quarters: decode, read, process, write
package bcce_pkg;
	localparam int PC_W = 21;
	localparam logic [7:0] OP_BR_OVF = 8'he4;
	localparam logic [7:0] OP_BR_ZERO = 8'he0;
	localparam logic [6:0] OP_CALL = 7'h76;
	localparam logic [3:0] OP_CALL2 = 4'hf;
	localparam logic [6:0] OP_CLR = 7'h35;
	localparam int Z_BIT = 2;
	localparam int OV_BIT = 3;
	localparam logic [7:0] ACC_SPLIT = 8'h80;
	localparam logic [3:0] ACC_HI_BANK = 4'hf;
	localparam logic [7:0] IDX_LIMIT = 8'h5f;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] RET_STEP = 21'h000002;
	localparam logic [15:0] IR_RESET = 16'h0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_PC = 8'h08;
	localparam logic [7:0] OFF_WORK = 8'h0c;
	localparam logic [7:0] OFF_BANK = 8'h10;
	localparam logic [7:0] OFF_SHADOW = 8'h14;
	localparam logic [7:0] OFF_STACK = 8'h18;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_EXT = 1;
	typedef enum logic [3:0] {
		Q1 = 4'b0001,
		Q2 = 4'b0010,
		Q3 = 4'b0100,
		Q4 = 4'b1000
	} phase_t;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic re;
		logic we;
	} dm_req_t;
endpackage : bcce_pkg

/* File: testbench/prog_data_model.sv */
`timescale 1ns/1ns
module prog_data_model (
	clk,
	arst_n,
	pm_addr,
	pm_rdata,
	dm_req,
	dm_rdata
);
	input wire logic clk;
	input wire logic arst_n;
	input wire logic [bcce_pkg::PC_W-1:0] pm_addr;
	output logic [15:0] pm_rdata;
	input wire bcce_pkg::dm_req_t dm_req;
	output logic [7:0] dm_rdata;
	logic [15:0] pmem [0:255];
	logic [7:0] dmem [0:4095];
	logic [7:0] last_q;
	logic [255:0] fetched;
	logic [11:0] waddr_q [$];
	logic [7:0] wdata_q [$];
	logic [11:0] raddr_q [$];
	// Async program read; the core samples it at the edge ending Q4
	assign pm_rdata = pmem[pm_addr[8:1]];
	// Read data only while selected, otherwise the inverse of the last value, so stale data comes back on every second idle cycle
	assign dm_rdata = dm_req.re ? dmem[dm_req.addr] : ~last_q;
	initial begin
		fetched = '0;
		last_q = 8'h00;
		for (int i = 0; i < 256; i++) pmem[i] = 16'h0000;
		for (int i = 0; i < 4096; i++) dmem[i] = 8'h5a;
	end
	always @(posedge clk) begin
		last_q <= dm_rdata;
		if (arst_n) fetched[pm_addr[8:1]] <= 1'b1;
		if (arst_n && dm_req.we) begin
			dmem[dm_req.addr] <= dm_req.wdata;
			waddr_q.push_back(dm_req.addr);
			wdata_q.push_back(dm_req.wdata);
		end
		if (arst_n && dm_req.re) raddr_q.push_back(dm_req.addr);
	end
endmodule : prog_data_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pm_rdata, rnd;
	logic [7:0] dm_rdata, st, wk, f2, f3, n;
	logic [11:0] index_base;
	logic [3:0] bk;
	logic [20:0] pm_addr, tgt;
	bcce_pkg::dm_req_t dm_req;
	int err_total, checks, cyc;
	logic er;
	branch_call_clear_execute i_branch_call_clear_execute (.clk(clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata), .index_base(index_base));
	prog_data_model i_prog_data_model (.clk(clk), .arst_n(arst_n), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	task automatic print_verdict;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp32
	task automatic cmp1(input string nm, input logic e, input logic g);
		cmp32(nm, {31'h0, e}, {31'h0, g});
	endtask : cmp1
	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		forever begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		err_total = 0;
		checks = 0;
		cyc = 0;
		rnd = 16'd20938;
		rnd = lfsr(rnd);
		index_base = rnd[11:0];
		arst_n = 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, bcce_pkg::OFF_STATUS, 32'h0);
		cmp32("status reset", 32'h0, rd);
		apb(1'b1, bcce_pkg::OFF_STACK, 32'hffff);
		apb(1'b0, bcce_pkg::OFF_STACK, 32'h0);
		cmp32("stack ro", 32'h0, rd);
		apb(1'b0, 8'h1c, 32'h0);
		cmp1("unmapped err", 1'b1, er);
		rnd = lfsr(rnd);
		st = rnd[7:0] & 8'hf3;
		wk = rnd[15:8];
		rnd = lfsr(rnd);
		bk = rnd[3:0];
		f2 = {1'b0, rnd[6:4] % 3'd6, rnd[11:8]};
		f3 = rnd[15:8];
		n = 8'd2 + {4'h0, rnd[3:0]};
		tgt = 21'd10 + {12'h0, n, 1'b0};
		apb(1'b1, bcce_pkg::OFF_STATUS, {24'h0, st});
		apb(1'b1, bcce_pkg::OFF_WORK, {24'h0, wk});
		apb(1'b1, bcce_pkg::OFF_BANK, {28'h0, bk});
		i_prog_data_model.pmem[0] = {bcce_pkg::OP_CLR, 1'b0, 8'h85};
		i_prog_data_model.pmem[1] = {bcce_pkg::OP_CLR, 1'b0, f2};
		i_prog_data_model.pmem[2] = {bcce_pkg::OP_CLR, 1'b1, f3};
		// Untaken target word 52 lies between the call word and call target word 40h, and is never fetched
		i_prog_data_model.pmem[3] = {bcce_pkg::OP_BR_OVF, 8'h30};
		i_prog_data_model.pmem[4] = {bcce_pkg::OP_BR_ZERO, n};
		i_prog_data_model.pmem[tgt[8:1]] = {bcce_pkg::OP_CALL, 1'b1, 8'h40};
		i_prog_data_model.pmem[tgt[8:1] + 8'd1] = {bcce_pkg::OP_CALL2, 12'h000};
		i_prog_data_model.pmem[8'h40] = {bcce_pkg::OP_BR_ZERO, 8'hff};
		apb(1'b1, bcce_pkg::OFF_CTRL, 32'h3);
		repeat (300) @(posedge clk);
		apb(1'b1, bcce_pkg::OFF_CTRL, 32'h0);
		cmp32("clear count", 32'd3, i_prog_data_model.waddr_q.size());
		cmp32("clear access", 32'hf85, {20'h0, i_prog_data_model.waddr_q[0]});
		cmp32("clear indexed", {20'h0, index_base + {4'h0, f2}},
			{20'h0, i_prog_data_model.waddr_q[1]});
		cmp32("clear banked", {20'h0, bk, f3}, {20'h0, i_prog_data_model.waddr_q[2]});
		cmp32("clear data", 32'h0, {24'h0, i_prog_data_model.wdata_q[2]});
		cmp32("clear reads", 32'd3, i_prog_data_model.raddr_q.size());
		cmp32("read addr", 32'hf85, {20'h0, i_prog_data_model.raddr_q[0]});
		cmp1("ovf branch untaken", 1'b0, i_prog_data_model.fetched[8'd52]);
		cmp1("zero branch skip", 1'b0, i_prog_data_model.fetched[tgt[8:1] - 8'd1]);
		cmp1("call target", 1'b1, i_prog_data_model.fetched[8'h40]);
		cmp1("no flush after call", 1'b0, i_prog_data_model.fetched[tgt[8:1] + 8'd2]);
		apb(1'b0, bcce_pkg::OFF_STACK, 32'h0);
		cmp32("return top", {11'h0, tgt + 21'd4}, rd);
		apb(1'b0, bcce_pkg::OFF_SHADOW, 32'h0);
		cmp32("shadows", {12'h0, bk, st | 8'h04, wk}, rd);
		apb(1'b0, bcce_pkg::OFF_STATUS, 32'h0);
		cmp32("status flags", {24'h0, st | 8'h04}, rd);
		apb(1'b0, bcce_pkg::OFF_PC, 32'h0);
		cmp1("pc even", 1'b0, rd[0]);
		print_verdict();
	end
endmodule : tb_top
